// *** src/wdog_pkg.sv ***
package wdog_pkg;

	// Register offsets (byte addresses)
	localparam logic [7:0]  WDOG_OFS_RELOAD_VALUE     = 8'h00;
	localparam logic [7:0]  WDOG_OFS_WATCHDOG_CONTROL = 8'h04;
	localparam logic [7:0]  WDOG_OFS_RELOAD_STROBE    = 8'h08;
	localparam logic [7:0]  WDOG_OFS_CURRENT_COUNT    = 8'h0C;

	// Control register fields
	localparam int          WDOG_CTL_ENABLE_BIT       = 0;
	localparam int          WDOG_CTL_STATUS_BIT       = 1;

	// Widths
	localparam int          WDOG_ADDR_W               = 8;
	localparam int          WDOG_DATA_W               = 32;
	localparam int          WDOG_CNT_W                = 16;

	// Values after reset
	localparam logic [15:0] WDOG_RELOAD_RST           = 16'h000F;
	localparam logic [15:0] WDOG_COUNT_RST            = 16'h000F;
	localparam logic        WDOG_ENABLE_RST           = 1'b0;
	localparam logic        WDOG_STATUS_RST           = 1'b0;
	localparam logic [31:0] WDOG_RDATA_RST            = 32'h0000_0000;

	// Slow clock periods per count step
	localparam int          WDOG_PRESCALE_DIV         = 33;
	localparam int          WDOG_PRESCALE_W           = 6;
	localparam logic [5:0]  WDOG_PRESCALE_LAST        = 6'(WDOG_PRESCALE_DIV - 1);
	localparam logic [5:0]  WDOG_PRESCALE_RST         = 6'h00;

	typedef enum logic [2:0] {
		WDOG_ST_IDLE    = 3'b001,
		WDOG_ST_RUN     = 3'b010,
		WDOG_ST_EXPIRED = 3'b100
	} wdog_state_t;

endpackage : wdog_pkg

// *** src/wdog_prescaler.sv ***
`timescale 1ns/1ps
module wdog_prescaler
	import wdog_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Slow clock pin
	input  wire logic slow_clock_32k,
	// Control side
	wdog_tick_if.pre  tck
);

	logic                       sync1_q;
	logic                       sync2_q;
	logic                       prev_q;
	logic [WDOG_PRESCALE_W-1:0] div_q;
	logic                       tick_q;
	logic                       slow_rise;

	// Two flops before any logic sees the pin
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= slow_clock_32k;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign slow_rise = sync2_q & ~prev_q;

	always_ff @(posedge clk) begin
		if (rst || !tck.run || tck.restart) begin
			div_q  <= WDOG_PRESCALE_RST;
			tick_q <= 1'b0;
		end else if (slow_rise) begin
			if (div_q == WDOG_PRESCALE_LAST) begin
				div_q  <= WDOG_PRESCALE_RST;
				tick_q <= 1'b1;
			end else begin
				div_q  <= div_q + 6'h01;
				tick_q <= 1'b0;
			end
		end else begin
			tick_q <= 1'b0;
		end
	end

	// tick gated by enable
	// A tick already in flight must not step a counter just halted
	assign tck.tick = tick_q & tck.run;

	property p_tick_after_last;
		@(posedge clk) disable iff (rst)
		tick_q |-> $past(div_q) == WDOG_PRESCALE_LAST && $past(slow_rise);
	endproperty
	a_tick_after_last: assert property (p_tick_after_last) else $error("tick without full divide");

	property p_tick_gated;
		@(posedge clk) disable iff (rst)
		!tck.run |=> !tick_q;
	endproperty
	a_tick_gated: assert property (p_tick_gated) else $error("tick while halted");

endmodule : wdog_prescaler

// *** src/wdog_tick_if.sv ***
`timescale 1ns/1ps
interface wdog_tick_if;
	logic run;
	logic restart;
	logic tick;

	modport ctl (
		output run,
		output restart,
		input  tick
	);

	modport pre (
		input  run,
		input  restart,
		output tick
	);
endinterface : wdog_tick_if

// *** src/wdog_timer.sv ***
`timescale 1ns/1ps
module wdog_timer
	import wdog_pkg::*;
(
	// Clock and main power reset
	input  wire logic                               clk,
	input  wire logic                               rst,
	// Slow clock pin
	input  wire logic                               slow_clock_32k,
	// Register port
	input  wire logic [wdog_pkg::WDOG_ADDR_W-1:0]   reg_addr,
	input  wire logic                               reg_wr_en,
	input  wire logic                               reg_rd_en,
	input  wire logic [wdog_pkg::WDOG_DATA_W-1:0]   reg_wdata,
	output logic      [wdog_pkg::WDOG_DATA_W-1:0]   reg_rdata,
	// Timeout event and state
	output logic                                    timeout_pulse,
	output logic                                    timeout_status_flag,
	output logic                                    counter_enable_bit
);
	import wdog_pkg::*;

	wdog_tick_if tck ();

	logic [WDOG_CNT_W-1:0]  reload_value_q;
	logic [WDOG_CNT_W-1:0]  count_q;
	logic                   enable_q;
	logic                   status_q;
	logic                   pulse_q;
	logic [WDOG_DATA_W-1:0] rdata_q;
	wdog_state_t            state_q;
	wdog_state_t            state_d;

	logic                   wr_reload;
	logic                   wr_ctl;
	logic                   wr_kick;
	logic                   kick_ok;
	logic                   underflow;
	logic                   status_w1c;
	logic                   restart;

	function automatic logic hit(input logic [WDOG_ADDR_W-1:0] a, input logic [WDOG_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign wr_reload  = reg_wr_en && hit(reg_addr, WDOG_OFS_RELOAD_VALUE);
	assign wr_ctl     = reg_wr_en && hit(reg_addr, WDOG_OFS_WATCHDOG_CONTROL);
	assign wr_kick    = reg_wr_en && hit(reg_addr, WDOG_OFS_RELOAD_STROBE);
	assign kick_ok    = wr_kick && enable_q;
	assign status_w1c = wr_ctl && reg_wdata[WDOG_CTL_STATUS_BIT];
	assign underflow  = (state_q == WDOG_ST_RUN) && tck.tick && (count_q == '0);
	assign restart    = wr_reload || kick_ok || underflow;

	assign tck.run     = enable_q;
	assign tck.restart = restart;

	wdog_prescaler u_prescaler (
		.clk            (clk),
		.rst            (rst),
		.slow_clock_32k (slow_clock_32k),
		.tck            (tck.pre)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			reload_value_q <= WDOG_RELOAD_RST;
		end else if (wr_reload) begin
			reload_value_q <= reg_wdata[WDOG_CNT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= WDOG_ENABLE_RST;
		end else if (wr_ctl) begin
			enable_q <= reg_wdata[WDOG_CTL_ENABLE_BIT];
		end
	end

	// Run state; expiry state lasts the single pulse cycle
	always_comb begin
		state_d = state_q;
		case (state_q)
			WDOG_ST_IDLE: begin
				if (enable_q) begin
					state_d = WDOG_ST_RUN;
				end
			end
			WDOG_ST_RUN: begin
				if (!enable_q) begin
					state_d = WDOG_ST_IDLE;
				end else if (underflow) begin
					state_d = WDOG_ST_EXPIRED;
				end
			end
			WDOG_ST_EXPIRED: begin
				state_d = enable_q ? WDOG_ST_RUN : WDOG_ST_IDLE;
			end
			default: begin
				state_d = WDOG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= WDOG_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// reload causes; a load write wins
	// counts down to zero then underflows
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= WDOG_COUNT_RST;
		end else if (wr_reload) begin
			count_q <= reg_wdata[WDOG_CNT_W-1:0];
		end else if (underflow || kick_ok) begin
			count_q <= reload_value_q;
		end else if (state_q == WDOG_ST_RUN && tck.tick) begin
			count_q <= count_q - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= underflow;
		end
	end

	// cleared otherwise by writing one to the status bit or by main reset
	// cleared to zero while main power reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			status_q <= WDOG_STATUS_RST;
		end else if (underflow) begin
			status_q <= 1'b1;
		end else if (status_w1c) begin
			status_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= WDOG_RDATA_RST;
		end else if (reg_rd_en) begin
			case (reg_addr)
				WDOG_OFS_RELOAD_VALUE:     rdata_q <= {16'h0000, reload_value_q};
				WDOG_OFS_WATCHDOG_CONTROL: rdata_q <= {30'h0000_0000, status_q, enable_q};
				WDOG_OFS_CURRENT_COUNT:    rdata_q <= {16'h0000, count_q};
				default:                   rdata_q <= WDOG_RDATA_RST;
			endcase
		end
	end

	assign reg_rdata           = rdata_q;
	assign timeout_pulse       = pulse_q;
	assign timeout_status_flag = status_q;
	assign counter_enable_bit  = enable_q;

	// Checks
	property p_load_reloads;
		@(posedge clk) disable iff (rst)
		wr_reload |=> count_q == $past(reg_wdata[WDOG_CNT_W-1:0]) && reload_value_q == count_q;
	endproperty
	a_load_reloads: assert property (p_load_reloads) else $error("load write did not reload");

	property p_kick_enabled;
		@(posedge clk) disable iff (rst)
		wr_kick && enable_q && !wr_reload |=> count_q == $past(reload_value_q);
	endproperty
	a_kick_enabled: assert property (p_kick_enabled) else $error("kick did not reload");

	property p_kick_disabled;
		@(posedge clk) disable iff (rst)
		wr_kick && !enable_q |=> $stable(count_q) && $stable(reload_value_q);
	endproperty
	a_kick_disabled: assert property (p_kick_disabled) else $error("kick acted while disabled");

	property p_halted;
		@(posedge clk) disable iff (rst)
		!enable_q && !wr_reload ##1 !enable_q |-> $stable(count_q);
	endproperty
	a_halted: assert property (p_halted) else $error("counter moved while disabled");

	property p_decrement;
		@(posedge clk) disable iff (rst)
		state_q == WDOG_ST_RUN && tck.tick && count_q != '0 && !wr_reload && !kick_ok
		|=> count_q == $past(count_q) - 16'h0001;
	endproperty
	a_decrement: assert property (p_decrement) else $error("counter did not step by one");

	property p_underflow_event;
		@(posedge clk) disable iff (rst)
		enable_q && state_q == WDOG_ST_RUN && tck.tick && count_q == '0
		|=> timeout_pulse && status_q ##1 !timeout_pulse;
	endproperty
	a_underflow_event: assert property (p_underflow_event) else $error("underflow event missing");

	property p_underflow_reload;
		@(posedge clk) disable iff (rst)
		underflow && !wr_reload |=> count_q == $past(reload_value_q);
	endproperty
	a_underflow_reload: assert property (p_underflow_reload) else $error("timeout did not reload");

	property p_status_sticky;
		@(posedge clk) disable iff (rst)
		status_q && !status_w1c |=> status_q;
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status flag dropped");

	property p_status_w1c;
		@(posedge clk) disable iff (rst)
		status_w1c && !underflow |=> !status_q;
	endproperty
	a_status_w1c: assert property (p_status_w1c) else $error("write one did not clear");

	property p_pulse_cause;
		@(posedge clk) disable iff (rst)
		timeout_pulse |-> $past(underflow) && $past(count_q) == '0;
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without underflow");

	property p_reset_defaults;
		@(posedge clk)
		rst |=> count_q == WDOG_COUNT_RST && reload_value_q == WDOG_RELOAD_RST
			&& !enable_q && !status_q && !timeout_pulse;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

	property p_kick_reads_zero;
		@(posedge clk) disable iff (rst)
		reg_rd_en && hit(reg_addr, WDOG_OFS_RELOAD_STROBE) |=> reg_rdata == WDOG_RDATA_RST;
	endproperty
	a_kick_reads_zero: assert property (p_kick_reads_zero) else $error("kick read not zero");

	property p_count_read;
		@(posedge clk) disable iff (rst)
		reg_rd_en && hit(reg_addr, WDOG_OFS_CURRENT_COUNT) |=> reg_rdata == {16'h0000, $past(count_q)};
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_status_set;
		@(posedge clk) disable iff (rst)
		underflow |=> status_q;
	endproperty
	a_status_set: assert property (p_status_set) else $error("status flag not set on timeout");

	property p_enable_write;
		@(posedge clk) disable iff (rst)
		wr_ctl |=> enable_q == $past(reg_wdata[WDOG_CTL_ENABLE_BIT]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write not taken");

	property p_ctl_read;
		@(posedge clk) disable iff (rst)
		reg_rd_en && hit(reg_addr, WDOG_OFS_WATCHDOG_CONTROL)
		|=> reg_rdata == {30'h0000_0000, $past(status_q), $past(enable_q)};
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

	property p_load_read;
		@(posedge clk) disable iff (rst)
		reg_rd_en && hit(reg_addr, WDOG_OFS_RELOAD_VALUE) |=> reg_rdata == {16'h0000, $past(reload_value_q)};
	endproperty
	a_load_read: assert property (p_load_read) else $error("load read wrong");

	property p_rdata_holds;
		@(posedge clk) disable iff (rst)
		!reg_rd_en |=> $stable(reg_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without a read");

endmodule : wdog_timer

// *** verif/wdog_timer_bench.sv ***
`timescale 1ns/1ps
module wdog_timer_bench;
	import wdog_pkg::*;
	// Slow clock runs at 8 host cycles per period to keep the run short
	localparam int STEP = 33 * 8;
	logic                   clk;
	logic                   rst;
	logic                   slow_clock_32k;
	logic                   reg_wr_en;
	logic                   reg_rd_en;
	logic [WDOG_ADDR_W-1:0] reg_addr;
	logic [WDOG_DATA_W-1:0] reg_wdata;
	logic [WDOG_DATA_W-1:0] reg_rdata;
	logic                   timeout_pulse;
	logic                   timeout_status_flag;
	logic                   counter_enable_bit;
	logic [31:0]            rv;
	int                     mismatches;
	int                     samples_checked;
	int                     n;

	wdog_timer u_dut (
		.clk                 (clk),
		.rst                 (rst),
		.slow_clock_32k      (slow_clock_32k),
		.reg_addr            (reg_addr),
		.reg_wr_en           (reg_wr_en),
		.reg_rd_en           (reg_rd_en),
		.reg_wdata           (reg_wdata),
		.reg_rdata           (reg_rdata),
		.timeout_pulse       (timeout_pulse),
		.timeout_status_flag (timeout_status_flag),
		.counter_enable_bit  (counter_enable_bit)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Offset keeps slow edges away from host clock edges
	initial begin
		slow_clock_32k = 1'b0;
		#3;
		forever #40 slow_clock_32k = ~slow_clock_32k;
	end

	task conclude();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk);
		reg_addr  = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		check(reg_rdata, exp);
	endtask : rd

	task wait_pulse();
		n = 0;
		while (timeout_pulse !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_pulse

	task t_reset();
		rd(WDOG_OFS_RELOAD_VALUE, 32'h0000_000F);
		rd(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0000);
		rd(WDOG_OFS_RELOAD_STROBE, 32'h0000_0000);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_000F);
		rd(8'h10, 32'h0000_0000);
		check({31'h0, timeout_pulse}, 32'h0);
		check({31'h0, timeout_status_flag}, 32'h0);
		check({31'h0, counter_enable_bit}, 32'h0);
	endtask : t_reset

	task t_load_halt();
		wr(WDOG_OFS_RELOAD_VALUE, 32'h0000_1234);
		rd(WDOG_OFS_RELOAD_VALUE, 32'h0000_1234);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_1234);
		repeat (3 * STEP) @(negedge clk);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_1234);
	endtask : t_load_halt

	task t_step_kick();
		wr(WDOG_OFS_RELOAD_VALUE, 32'h0000_000A);
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0001);
		check({31'h0, counter_enable_bit}, 32'h1);
		repeat (STEP - 40) @(negedge clk);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_000A);
		repeat (60) @(negedge clk);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_0009);
		wr(WDOG_OFS_RELOAD_STROBE, 32'h0000_0000);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_000A);
		rd(WDOG_OFS_RELOAD_STROBE, 32'h0000_0000);
		repeat (STEP + 40) @(negedge clk);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_0009);
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0000);
		check({31'h0, counter_enable_bit}, 32'h0);
		repeat (3 * STEP) @(negedge clk);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_0009);
		wr(WDOG_OFS_RELOAD_STROBE, 32'h0000_0000);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_0009);
	endtask : t_step_kick

	task t_timeout();
		wr(WDOG_OFS_RELOAD_VALUE, 32'h0000_0001);
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0001);
		wait_pulse();
		check({31'h0, n >= 500 && n <= 540}, 32'h1);
		check({31'h0, timeout_status_flag}, 32'h1);
		@(negedge clk);
		check({31'h0, timeout_pulse}, 32'h0);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_0001);
		rd(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0003);
	endtask : t_timeout

	task t_w1c();
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0001);
		rd(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0003);
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0002);
		rd(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0000);
		check({31'h0, timeout_status_flag}, 32'h0);
	endtask : t_w1c

	task t_rst();
		wr(WDOG_OFS_RELOAD_VALUE, 32'h0000_0001);
		wr(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0001);
		wait_pulse();
		check({31'h0, timeout_pulse}, 32'h1);
		@(negedge clk);
		check({31'h0, timeout_status_flag}, 32'h1);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check({31'h0, counter_enable_bit}, 32'h0);
		rd(WDOG_OFS_WATCHDOG_CONTROL, 32'h0000_0000);
		rd(WDOG_OFS_RELOAD_VALUE, 32'h0000_000F);
		rd(WDOG_OFS_CURRENT_COUNT, 32'h0000_000F);
	endtask : t_rst

	initial begin
		mismatches      = 0;
		samples_checked = 0;
		rst             = 1'b1;
		reg_wr_en       = 1'b0;
		reg_rd_en       = 1'b0;
		reg_addr        = 8'h00;
		reg_wdata       = 32'h0000_0000;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_load_halt();
		t_step_kick();
		t_timeout();
		t_w1c();
		t_rst();
		conclude();
	end

	// Whole sequence needs about 3300 cycles
	initial begin
		repeat (20000) @(negedge clk);
		mismatches++;
		conclude();
	end
endmodule : wdog_timer_bench
